// File: core/dbd_defines.svh
// Constants for the delayed-branch decoder
// What this block does
// - Decode opcode 15..8, zero bit 7, field 6..1, sign bit 0; offset sign-extended.
// - Displacement is an even signed byte distance from -128 to +126.
// - Target is displacement plus address of first byte after the branch.
// - Opcode e8 branches only when negative flag is one.
// - Opcode e9 branches only when negative flag is zero.
// - Opcode e5 branches only when carry flag is zero.
// - Opcode e3 branches only when zero flag is zero.
// - Opcode e1 branches only when overflow flag is zero.
// - Opcode e6 branches when carry or zero flag is one.
// - Opcode ec always loads the target, then runs the delay instruction.
// - Condition flags and cache-mode flag stay unchanged by any delayed branch.
// - The single instruction after a delayed branch always executes.
// - Not taken: delay instruction runs normally, PC and length code advance.
// - Taken: delay instruction finishes first, does not advance PC holding target.
// - Taken: PC operand read by delay instruction yields the target.
`ifndef DBD_DEFINES_SVH
`define DBD_DEFINES_SVH
`define DBD_OP_JUMP_IF_MINUS 8'he8
`define DBD_OP_JUMP_IF_PLUS 8'he9
`define DBD_OP_JUMP_IF_CARRY_CLEAR 8'he5
`define DBD_OP_JUMP_IF_NONZERO 8'he3
`define DBD_OP_JUMP_IF_NO_OVERFLOW 8'he1
`define DBD_OP_JUMP_IF_BELOW_OR_SAME 8'he6
`define DBD_OP_JUMP_ALWAYS 8'hec
`define DBD_OPC_MSB 15
`define DBD_OPC_LSB 8
`define DBD_ZERO_BIT 7
`define DBD_FIELD_MSB 6
`define DBD_FIELD_LSB 1
`define DBD_SIGN_BIT 0
`define DBD_SIGN_REPEAT 25
`define DBD_BRANCH_BYTES 32'h0000_0002
`define DBD_PC_RESET 32'h0000_0000
`endif

// File: core/dbd_delayed_branch.sv
// Delayed-branch decode and program counter sequencing
`timescale 1ns/10ps
`default_nettype none
`include "dbd_defines.svh"
module dbd_delayed_branch (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic instrValid,
    input wire logic [15:0] instr,
    input wire logic [1:0] instrLength,
    input wire dbd_pkg::dbd_flags_t flagsIn,
    input wire logic delayException,
    output logic [31:0] pc,
    output logic [31:0] pcOperand,
    output dbd_pkg::dbd_flags_t flagsOut,
    output logic [1:0] instruction_length_code,
    output logic branchTaken,
    output logic inDelaySlot,
    output logic exceptionOut
);
    import dbd_pkg::*;

    dbd_decode_t dec;
    dbd_state_t state;
    dbd_state_t next_state;
    logic condMet;
    logic [31:0] seqPc;
    logic [31:0] target;
    logic [31:0] next_pc;
    logic isBranchNow;

    dbd_field_decode fieldDecode (
        .instr(instr),
        .dec(dec)
    );

    // Only instructions outside the delay slot may open a new delayed branch
    assign isBranchNow = instrValid && dec.isBranch && (state == DBD_ST_NORMAL);

    // Condition test on the live flags
    always_comb begin
        unique case (dec.cond)
            DBD_JMP_MINUS: condMet = flagsIn.neg;
            DBD_JMP_PLUS: condMet = !flagsIn.neg;
            DBD_JMP_CARRY_CLEAR: condMet = !flagsIn.carry;
            DBD_JMP_NONZERO: condMet = !flagsIn.zero;
            DBD_JMP_NO_OVERFLOW: condMet = !flagsIn.ovf;
            DBD_JMP_BELOW_OR_SAME: condMet = flagsIn.carry || flagsIn.zero;
            DBD_JMP_ALWAYS: condMet = 1'b1;
            DBD_JMP_NONE: condMet = 1'b0;
        endcase
    end

    // target from address after the branch
    always_comb begin
        seqPc = pc + {29'h0, instrLength, 1'b0};
        target = pc + `DBD_BRANCH_BYTES + dec.disp;
    end

    // Next state and next pc
    always_comb begin
        next_state = state;
        next_pc = pc;
        if (instrValid) begin
            unique case (state)
                DBD_ST_NORMAL: begin
                    if (isBranchNow && condMet) begin
                        // pc holds the target through the slot
                        next_pc = target;
                        next_state = DBD_ST_DELAY_TAKEN;
                    end else if (isBranchNow) begin
                        // untaken branch steps over its own halfword only
                        next_pc = pc + `DBD_BRANCH_BYTES;
                        next_state = DBD_ST_DELAY_SEQ;
                    end else begin
                        next_pc = seqPc;
                    end
                end
                DBD_ST_DELAY_SEQ: begin
                    next_pc = seqPc;
                    next_state = DBD_ST_NORMAL;
                end
                DBD_ST_DELAY_TAKEN: begin
                    next_pc = pc;
                    next_state = DBD_ST_NORMAL;
                end
                default: begin
                    next_pc = pc;
                    next_state = DBD_ST_NORMAL;
                end
            endcase
        end
    end

    // slot state always serves one instruction
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= DBD_ST_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // Program counter register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pc <= `DBD_PC_RESET;
        end else begin
            pc <= next_pc;
        end
    end

    // operand seen by the delay instruction
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pcOperand <= `DBD_PC_RESET;
        end else if (next_state == DBD_ST_DELAY_TAKEN) begin
            pcOperand <= next_pc;
        end else begin
            pcOperand <= next_pc + `DBD_BRANCH_BYTES;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flagsOut <= '0;
        end else begin
            flagsOut <= flagsIn;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            instruction_length_code <= 2'h0;
        end else if (instrValid && state != DBD_ST_DELAY_TAKEN) begin
            instruction_length_code <= instrLength;
        end
    end

    // Status strobes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            branchTaken <= 1'b0;
            inDelaySlot <= 1'b0;
        end else begin
            branchTaken <= isBranchNow && condMet;
            inDelaySlot <= next_state != DBD_ST_NORMAL;
        end
    end

    // only the delay instruction can fault
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            exceptionOut <= 1'b0;
        end else begin
            exceptionOut <= delayException && instrValid && (state != DBD_ST_NORMAL);
        end
    end
endmodule
`default_nettype wire

// File: core/dbd_field_decode.sv
// Combinational decode of the pc-relative delayed-branch format
`timescale 1ns/10ps
`default_nettype none
`include "dbd_defines.svh"
module dbd_field_decode (
    input wire logic [15:0] instr,
    output dbd_pkg::dbd_decode_t dec
);
    import dbd_pkg::*;

    // Opcode to condition class
    function automatic dbd_cond_t opToCond(input logic [7:0] op);
        case (op)
            `DBD_OP_JUMP_IF_MINUS: opToCond = DBD_JMP_MINUS;
            `DBD_OP_JUMP_IF_PLUS: opToCond = DBD_JMP_PLUS;
            `DBD_OP_JUMP_IF_CARRY_CLEAR: opToCond = DBD_JMP_CARRY_CLEAR;
            `DBD_OP_JUMP_IF_NONZERO: opToCond = DBD_JMP_NONZERO;
            `DBD_OP_JUMP_IF_NO_OVERFLOW: opToCond = DBD_JMP_NO_OVERFLOW;
            `DBD_OP_JUMP_IF_BELOW_OR_SAME: opToCond = DBD_JMP_BELOW_OR_SAME;
            `DBD_OP_JUMP_ALWAYS: opToCond = DBD_JMP_ALWAYS;
            default: opToCond = DBD_JMP_NONE;
        endcase
    endfunction

    dbd_cond_t cond;

    always_comb begin
        cond = opToCond(instr[`DBD_OPC_MSB:`DBD_OPC_LSB]);
        dec.isBranch = (cond != DBD_JMP_NONE) && !instr[`DBD_ZERO_BIT];
        dec.cond = cond;
        dec.disp = {{`DBD_SIGN_REPEAT{instr[`DBD_SIGN_BIT]}}, instr[`DBD_FIELD_MSB:`DBD_FIELD_LSB], 1'b0};
    end
endmodule
`default_nettype wire

// File: core/dbd_pkg.sv
// Types shared by the delayed-branch decoder files
package dbd_pkg;
    typedef struct packed {
        logic neg;
        logic zero;
        logic carry;
        logic ovf;
        logic cacheMode;
    } dbd_flags_t;

    typedef enum logic [2:0] {
        DBD_JMP_MINUS = 3'h0,
        DBD_JMP_PLUS = 3'h1,
        DBD_JMP_CARRY_CLEAR = 3'h2,
        DBD_JMP_NONZERO = 3'h3,
        DBD_JMP_NO_OVERFLOW = 3'h4,
        DBD_JMP_BELOW_OR_SAME = 3'h5,
        DBD_JMP_ALWAYS = 3'h6,
        DBD_JMP_NONE = 3'h7
    } dbd_cond_t;

    typedef struct packed {
        logic isBranch;
        dbd_cond_t cond;
        logic [31:0] disp;
    } dbd_decode_t;

    typedef enum logic [1:0] {
        DBD_ST_NORMAL = 2'b00,
        DBD_ST_DELAY_SEQ = 2'b01,
        DBD_ST_DELAY_TAKEN = 2'b10
    } dbd_state_t;
endpackage

// File: sim/dbd_asserts.sv
// Port checks for the delayed-branch decoder
`timescale 1ns/10ps
`default_nettype none
module dbd_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic instrValid,
    input wire logic [15:0] instr,
    input wire logic [1:0] instrLength,
    input wire dbd_pkg::dbd_flags_t flagsIn,
    input wire logic delayException,
    input wire logic [31:0] pc,
    input wire logic [31:0] pcOperand,
    input wire dbd_pkg::dbd_flags_t flagsOut,
    input wire logic [1:0] instruction_length_code,
    input wire logic branchTaken,
    input wire logic inDelaySlot,
    input wire logic exceptionOut
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic isBr, tk;
    logic [31:0] disp;
    always_comb begin
        disp = {{25{instr[0]}}, instr[6:1], 1'b0};
        isBr = !instr[7] && instr[15:8] inside {8'he8, 8'he9, 8'he5, 8'he3, 8'he1, 8'he6, 8'hec};
        case (instr[15:8])
            8'he8: tk = flagsIn.neg;
            8'he9: tk = !flagsIn.neg;
            8'he5: tk = !flagsIn.carry;
            8'he3: tk = !flagsIn.zero;
            8'he1: tk = !flagsIn.ovf;
            8'he6: tk = flagsIn.carry | flagsIn.zero;
            default: tk = 1'b1;
        endcase
    end
    // A branch only counts outside a delay slot
    wire logic br = instrValid && !inDelaySlot && isBr;
    a_taken_target: assert property (br && tk |=> pc == $past(pc) + 32'h2 + $past(disp))
        else $error("bad target");
    a_untaken_step: assert property (br && !tk |=> pc == $past(pc) + 32'h2)
        else $error("bad step");
    a_slot_follows: assert property (br |=> inDelaySlot && branchTaken == $past(tk))
        else $error("bad outcome");
    a_slot_hold: assert property (instrValid && inDelaySlot && branchTaken |=> pc == $past(pc) && !inDelaySlot)
        else $error("slot moved pc");
    a_ilc_held: assert property (instrValid && inDelaySlot && branchTaken
        |=> $stable(instruction_length_code))
        else $error("length code moved");
    a_operand_target: assert property (branchTaken |-> pcOperand == pc)
        else $error("bad operand");
    a_flags_kept: assert property (instrValid |=> flagsOut == $past(flagsIn))
        else $error("flags changed");
    a_branch_quiet: assert property (br |=> !exceptionOut)
        else $error("branch raised");
    a_slot_exc: assert property (instrValid && inDelaySlot && delayException |=> exceptionOut)
        else $error("slot exception lost");
    c_taken: cover property (br && tk);
    c_untaken: cover property (br && !tk);
    c_slot_exc: cover property (instrValid && inDelaySlot && delayException);
endmodule
bind dbd_delayed_branch dbd_chk chk (.*);
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the delayed-branch decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic instrValid = 1'b0;
    logic [15:0] instr = 16'h0;
    logic [1:0] instrLength = 2'h1;
    dbd_pkg::dbd_flags_t flagsIn = '0;
    logic delayException = 1'b0;
    logic [31:0] pc;
    logic [31:0] pcOperand;
    logic [31:0] modelPc = 32'h0;
    logic inSlot = 1'b0;
    logic slotTaken = 1'b0;
    logic [7:0] ops [7] = '{8'he8, 8'he9, 8'he5, 8'he3, 8'he1, 8'he6, 8'hec};
    logic [31:0] q [$];
    logic [31:0] qOp [$];
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    always #10 ref_clk = ~ref_clk;
    dbd_delayed_branch DUT (.ref_clk(ref_clk), .rst(rst), .instrValid(instrValid), .instr(instr),
        .instrLength(instrLength), .flagsIn(flagsIn), .delayException(delayException), .pc(pc),
        .pcOperand(pcOperand), .flagsOut(), .instruction_length_code(), .branchTaken(), .inDelaySlot(),
        .exceptionOut());
    task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic take(input logic [7:0] op, input dbd_pkg::dbd_flags_t f);
        case (op)
            8'he8: return f.neg;
            8'he9: return !f.neg;
            8'he5: return !f.carry;
            8'he3: return !f.zero;
            8'he1: return !f.ovf;
            8'he6: return f.carry | f.zero;
            default: return 1'b1;
        endcase
    endfunction
    // Drive one instruction and note the pc it must leave
    task automatic ex(input logic [15:0] i, input logic [1:0] len);
        logic tkNow;
        tkNow = 1'b0;
        @(posedge ref_clk);
        #1;
        instr = i;
        instrLength = len;
        flagsIn = 5'($urandom);
        delayException = 1'($urandom);
        instrValid = 1'b1;
        if (inSlot) begin
            modelPc += slotTaken ? 32'h0 : {29'h0, len, 1'b0};
            inSlot = 1'b0;
        end else if (!i[7] && i[15:8] inside {ops}) begin
            slotTaken = take(i[15:8], flagsIn);
            tkNow = slotTaken;
            inSlot = 1'b1;
            modelPc += slotTaken ? 32'h2 + {{25{i[0]}}, i[6:1], 1'b0} : 32'h2;
        end else begin
            modelPc += {29'h0, len, 1'b0};
        end
        q.push_back(modelPc);
        // Taken slot reads the target, otherwise the address after the next halfword
        qOp.push_back(tkNow ? modelPc : modelPc + 32'h2);
    endtask
    // Compare pc once each executed instruction has landed
    always @(posedge ref_clk) begin
        if (instrValid && !rst) begin
            #2;
            cmp(q.pop_front(), pc);
            cmp(qOp.pop_front(), pcOperand);
        end
    end
    // Hang guard, far above the planned run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(32'h7602));
        repeat (20) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        // displacement extremes, branch opcode in a slot
        ex(16'hec01, 2'h1);
        ex(16'h0000, 2'h2);
        ex(16'hec7e, 2'h1);
        ex(16'he87e, 2'h3);
        repeat (300) ex({ops[$urandom % 7], 8'($urandom)}, 2'($urandom % 3 + 1));
        @(posedge ref_clk);
        #1;
        instrValid = 1'b0;
        repeat (3) @(posedge ref_clk);
        end_of_test();
    end
endmodule
`default_nettype wire
